// File: logic/dlb_exec.sv
// divide and count-down-branch execution unit
//
// What this block does
// - word divide direct address: opcode 01 011011, src 0; 108/109/111 cycles
// - long divide direct address: opcode 01 011010, src 0; 445/746/748 cycles
// - segmented indexed long form flagged by bit 15; 112 and 749 cycles
// - divide by zero finishes 94 (word) or 714 (long) cycles sooner; long direct nonsegmented wraps to 755 cycles
// - quotient overflow finishes 82 (word) or 693 (long) cycles sooner; long direct nonsegmented wraps to 776 cycles
// - word divide: odd register gets quotient, even register remainder
// - loop decrements the named counter and writes it back
// - nonzero counter: branch target loaded into program counter
// - zero counter: fall through to the next instruction
// - target is next instruction address minus twice displacement
// - displacement is unsigned 7 bits, 0 to 127, backward only
// - segmented branch changes only the pc offset, never the segment
// - quotient to low half, remainder to high half, source untouched
// - operands signed two's complement; remainder takes dividend sign
// - divide by zero leaves destination unchanged and sets overflow
`timescale 1ns/10ps
`include "dlb_regs.svh"
module dlb_exec (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // issue
   input  wire logic              start,
   input  wire dlb_pkg::dlb_cmd_t cmd,
   input  wire dlb_pkg::dlb_opnd_t opnd,
   input  wire logic [15:0]       cnt_in,
   input  wire logic [15:0]       pc_next,
   input  wire logic [6:0]        pc_seg,
   // completion
   output dlb_pkg::dlb_res_t      res,
   output logic [15:0]            cnt_out,
   output logic                   cnt_we,
   output logic [15:0]            pc_out,
   output logic [6:0]             pc_seg_out,
   output logic                   pc_we,
   output logic                   done,
   output logic                   busy,
   output logic                   illegal
);
   dlb_pkg::dlb_state_t state_r;
   logic [9:0]  cyc_r;
   logic [9:0]  cyc_nxt;
   logic [63:0] div_dst;
   logic        div_zero;
   logic        div_ovf;
   logic        is_long;
   logic        legal_div;
   logic [15:0] cnt_dec;
   logic        cmd_loop_r;

   assign is_long = (cmd.op_word[13:8] == `DLB_OPC_QUOTIENT_LONG_OP);

   dlb_divider u_div (
      .long_op  (is_long),
      .dividend (opnd.dst),
      .divisor  (opnd.src),
      .dst_out  (div_dst),
      .div_zero (div_zero),
      .ovf      (div_ovf)
   );

   // listed cycle count for a direct or indexed divide
   function automatic logic [9:0] base_cycles(input logic lng, input logic idx,
                                               input logic seg, input logic sl);
      logic [9:0] c;
      c = 10'd0;
      if (!lng) begin
         if (!seg)    c = idx ? `DLB_CYC_DIVW_XNS : `DLB_CYC_DIVW_NS;
         else if (sl) c = idx ? `DLB_CYC_DIVW_XSL : `DLB_CYC_DIVW_SL;
         else         c = `DLB_CYC_DIVW_SS;
      end else begin
         if (!seg)    c = idx ? `DLB_CYC_QUOTIENT_LONG_OP_XNS : `DLB_CYC_QUOTIENT_LONG_OP_NS;
         else if (sl) c = idx ? `DLB_CYC_QUOTIENT_LONG_OP_XSL : `DLB_CYC_QUOTIENT_LONG_OP_SL;
         else         c = `DLB_CYC_QUOTIENT_LONG_OP_SS;
      end
      return c;
   endfunction : base_cycles

   // only the direct and indexed forms are executed here; register, immediate
   // and indirect encodings are flagged illegal and left to other units
   assign legal_div = (cmd.op_word[15:14] == `DLB_MODE_DA_X) &&
                      ((cmd.op_word[13:8] == `DLB_OPC_DIVW) ||
                       (cmd.op_word[13:8] == `DLB_OPC_QUOTIENT_LONG_OP));

   always_comb begin
      cyc_nxt = base_cycles(is_long, cmd.op_word[7:4] != 4'h0, cmd.segmented,
                            cmd.ext_word[`DLB_LONG_FLAG_BIT]);
      if (div_zero)
         cyc_nxt = cyc_nxt - (is_long ? `DLB_ZERO_CUT_L : `DLB_ZERO_CUT_W);
      else if (div_ovf)
         cyc_nxt = cyc_nxt - (is_long ? `DLB_OVF_CUT_L : `DLB_OVF_CUT_W);
      if (cmd.is_loop)
         cyc_nxt = `DLB_LOOP_CYC;
   end

   // byte form wraps in 8 bits, word form in 16
   assign cnt_dec = cmd.byte_form ? {8'h00, cnt_in[7:0] - 8'h01} : cnt_in - 16'h0001;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= dlb_pkg::DLB_IDLE;
         cyc_r   <= 10'd0;
      end else begin
         case (state_r)
            dlb_pkg::DLB_IDLE: begin
               if (start && (cmd.is_loop || legal_div)) begin
                  state_r <= dlb_pkg::DLB_BUSY;
                  cyc_r   <= cyc_nxt - 10'd1;
               end
            end
            dlb_pkg::DLB_BUSY: begin
               if (cyc_r <= 10'd1)
                  state_r <= dlb_pkg::DLB_DONE;
               else
                  cyc_r <= cyc_r - 10'd1;
            end
            dlb_pkg::DLB_DONE: state_r <= dlb_pkg::DLB_IDLE;
            default:           state_r <= dlb_pkg::DLB_IDLE;
         endcase
      end
   end

   // results are captured at issue; operands need not be held
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res        <= '0;
         cnt_out    <= 16'h0000;
         pc_out     <= 16'h0000;
         pc_seg_out <= 7'h00;
         illegal    <= 1'b0;
      end else if (state_r == dlb_pkg::DLB_IDLE && start) begin
         illegal <= !(cmd.is_loop || legal_div);
         if (cmd.is_loop) begin
            res.dst_we  <= 1'b0;
            res.flag_we <= 1'b0;
            cnt_out     <= cnt_dec;
            // unsigned 7-bit displacement, doubled, subtracted
            pc_out      <= (cnt_dec != 16'h0000) ?
                           pc_next - {8'h00, cmd.op_word[`DLB_DISP_W-1:0], 1'b0} :
                           pc_next;
            pc_seg_out  <= pc_seg;
         end else begin
            res.dst     <= div_zero ? opnd.dst : div_dst;
            res.dst_we  <= legal_div && !div_zero;
            res.flag_we <= legal_div;
            res.ovf     <= div_zero || div_ovf;
            res.carry   <= div_ovf && !div_zero;
            res.zero    <= !div_zero && (is_long ? div_dst[31:0] == 32'h0000_0000 :
                                                   div_dst[15:0] == 16'h0000);
            res.sign    <= !div_zero && (is_long ? div_dst[31] : div_dst[15]);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         done   <= 1'b0;
         busy   <= 1'b0;
         cnt_we <= 1'b0;
         pc_we  <= 1'b0;
      end else begin
         done   <= (state_r == dlb_pkg::DLB_BUSY) && (cyc_r <= 10'd1);
         // the done state already reads as free, so no stray busy cycle follows done
         busy   <= (state_r == dlb_pkg::DLB_IDLE) ? (start && (cmd.is_loop || legal_div))
                                                   : ((state_r == dlb_pkg::DLB_BUSY) &&
                                                      (cyc_r > 10'd1));
         cnt_we <= (state_r == dlb_pkg::DLB_BUSY) && (cyc_r <= 10'd1) && cmd_loop_r;
         pc_we  <= (state_r == dlb_pkg::DLB_BUSY) && (cyc_r <= 10'd1) && cmd_loop_r;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         cmd_loop_r <= 1'b0;
      else if (state_r == dlb_pkg::DLB_IDLE && start)
         cmd_loop_r <= cmd.is_loop;
   end

   // flags never written by the loop instruction
   a_loop_flags: assert property (@(posedge ref_clk) disable iff (rst)
      done && cmd_loop_r |-> !res.flag_we) else $error("loop wrote flags");
   // zero divisor keeps destination
   a_zero_keep: assert property (@(posedge ref_clk) disable iff (rst)
      done && !cmd_loop_r && res.ovf && !res.carry |-> !res.dst_we)
      else $error("zero divide wrote destination");
   // the branch copies the segment seen at issue, whatever the offset does
   a_seg_keep: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == dlb_pkg::DLB_IDLE && start && cmd.is_loop |=> pc_seg_out == $past(pc_seg))
      else $error("segment changed");
   // a counter that reaches zero falls through to the following instruction
   a_pc_back: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == dlb_pkg::DLB_IDLE && start && cmd.is_loop && cnt_dec == 16'h0000
      |=> pc_out == $past(pc_next))
      else $error("pc moved on zero count");
   // busy drops with the completion pulse and stays low after it
   a_busy_done: assert property (@(posedge ref_clk) disable iff (rst)
      done |-> !busy ##1 !busy) else $error("busy after completion");
   sequence s_word_ns;
      state_r == dlb_pkg::DLB_IDLE && start && !cmd.is_loop && legal_div && !is_long
      && !cmd.segmented && cmd.op_word[7:4] == 4'h0 && !div_zero && !div_ovf;
   endsequence
   a_divw_time: assert property (@(posedge ref_clk) disable iff (rst)
      s_word_ns |-> ##108 done) else $error("word divide timing");
   sequence s_loop_go;
      state_r == dlb_pkg::DLB_IDLE && start && cmd.is_loop;
   endsequence
   a_loop_time: assert property (@(posedge ref_clk) disable iff (rst)
      s_loop_go |-> ##11 (done && pc_we)) else $error("loop timing");
   a_divw_zero: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == dlb_pkg::DLB_IDLE && start && legal_div && !is_long && !cmd.segmented
      && cmd.op_word[7:4] == 4'h0 && div_zero |-> ##14 done)
      else $error("zero divide timing");
   a_divw_ovf: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == dlb_pkg::DLB_IDLE && start && legal_div && !is_long && !cmd.segmented
      && cmd.op_word[7:4] == 4'h0 && !div_zero && div_ovf |-> ##26 done)
      else $error("overflow divide timing");
endmodule : dlb_exec

// File: logic/dlb_regs.svh
// timing, opcode and field constants for the divide and loop-branch executor
`ifndef DLB_REGS_SVH
`define DLB_REGS_SVH
`define DLB_OPC_DIVW        6'h1B
`define DLB_OPC_QUOTIENT_LONG_OP        6'h1A
`define DLB_MODE_DA_X       2'h1
`define DLB_CYC_DIVW_NS     10'd108
`define DLB_CYC_DIVW_SS     10'd109
`define DLB_CYC_DIVW_SL     10'd111
`define DLB_CYC_DIVW_XNS    10'd109
`define DLB_CYC_DIVW_XSL    10'd112
`define DLB_CYC_QUOTIENT_LONG_OP_NS     10'd445
`define DLB_CYC_QUOTIENT_LONG_OP_SS     10'd746
`define DLB_CYC_QUOTIENT_LONG_OP_SL     10'd748
`define DLB_CYC_QUOTIENT_LONG_OP_XNS    10'd746
`define DLB_CYC_QUOTIENT_LONG_OP_XSL    10'd749
`define DLB_ZERO_CUT_W      10'd94
`define DLB_ZERO_CUT_L      10'd714
`define DLB_OVF_CUT_W       10'd82
`define DLB_OVF_CUT_L       10'd693
`define DLB_LOOP_CYC        10'd11
`define DLB_LONG_FLAG_BIT   15
`define DLB_DISP_W          7
`endif

// File: logic/dlb_pkg.sv
// types shared by the divide and loop-branch executor
package dlb_pkg;
   typedef enum logic [1:0] {DLB_IDLE, DLB_BUSY, DLB_DONE} dlb_state_t;

   typedef struct packed {
      logic        is_loop;
      logic        byte_form;
      logic [15:0] op_word;
      logic [15:0] ext_word;
      logic        segmented;
   } dlb_cmd_t;

   typedef struct packed {
      logic [63:0] dst;
      logic [31:0] src;
   } dlb_opnd_t;

   typedef struct packed {
      logic [63:0] dst;
      logic        dst_we;
      logic        flag_we;
      logic        ovf;
      logic        carry;
      logic        zero;
      logic        sign;
   } dlb_res_t;
endpackage : dlb_pkg

// File: logic/dlb_divider.sv
// combinational signed divider, word or long
`timescale 1ns/10ps
module dlb_divider (
   // operands
   input  wire logic        long_op,
   input  wire logic [63:0] dividend,
   input  wire logic [31:0] divisor,
   // results
   output logic      [63:0] dst_out,
   output logic             div_zero,
   output logic             ovf
);
   logic signed [64:0] n;
   logic signed [64:0] d;
   logic signed [64:0] q;
   logic signed [64:0] r;

   always_comb begin
      n = long_op ? {dividend[63], dividend} : {{33{dividend[31]}}, dividend[31:0]};
      d = long_op ? {{33{divisor[31]}}, divisor} : {{49{divisor[15]}}, divisor[15:0]};
      div_zero = (d == 65'sd0);
      // truncating division gives remainder with the dividend's sign
      q = div_zero ? 65'sd0 : n / d;
      r = div_zero ? 65'sd0 : n % d;
      if (long_op) begin
         ovf = (q > 65'sh0_7FFF_FFFF) || (q < -65'sh0_8000_0000);
         dst_out = {r[31:0], q[31:0]};
      end else begin
         ovf = (q > 65'sh7FFF) || (q < -65'sh8000);
         // odd (low) word holds quotient, even (high) word the remainder
         dst_out = {32'h0000_0000, r[15:0], q[15:0]};
      end
   end
endmodule : dlb_divider

// File: verification/dlb_exec_tb.sv
// self-checking bench for the divide and count-down-branch executor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module divide_and_loop_branch_exec_tb;
   logic                ref_clk    = 1'b0;
   logic                rst        = 1'b1;
   logic                start      = 1'b0;
   dlb_pkg::dlb_cmd_t   cmd        = '0;
   dlb_pkg::dlb_opnd_t  opnd       = '0;
   logic [15:0]         cnt_in     = 16'h0000;
   logic [15:0]         pc_next    = 16'h1000;
   logic [6:0]          pc_seg     = 7'h2a;
   dlb_pkg::dlb_res_t   res;
   logic [15:0]         cnt_out;
   logic [15:0]         pc_out;
   logic [6:0]          pc_seg_out;
   logic                cnt_we;
   logic                pc_we;
   logic                done;
   logic                busy;
   logic                illegal;
   int                  failures   = 0;
   int                  num_checks = 0;

   always #25 ref_clk = ~ref_clk;

   dlb_exec dut_u (
      .ref_clk(ref_clk), .rst(rst), .start(start), .cmd(cmd), .opnd(opnd), .cnt_in(cnt_in),
      .pc_next(pc_next), .pc_seg(pc_seg), .res(res), .cnt_out(cnt_out), .cnt_we(cnt_we),
      .pc_out(pc_out), .pc_seg_out(pc_seg_out), .pc_we(pc_we), .done(done), .busy(busy),
      .illegal(illegal)
   );

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic issue(input dlb_pkg::dlb_cmd_t c, input logic [63:0] dd, input logic [31:0] ds,
                        input logic [15:0] ct);
      @(posedge ref_clk);
      cmd <= c;
      opnd <= {dd, ds};
      cnt_in <= ct;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
   endtask : issue

   // n is the cycle number after the taking edge, so done shows in cycle N;
   // gives up at 1200 when no done comes
   task automatic wait_done(output int n);
      n = 1;
      do begin
         @(posedge ref_clk);
         n++;
         #1;
      end while (done !== 1'b1 && n < 1200);
   endtask : wait_done

   // kind: 0 normal, 1 zero divisor, 2 quotient overflow
   task automatic div_case(input logic lng, input logic seg, input logic sl, input logic idx,
                           input logic [63:0] dd, input logic [31:0] ds, input int exp_n,
                           input int kind, input logic [63:0] exp_d);
      dlb_pkg::dlb_cmd_t c;
      int                n;
      c = '{1'b0, 1'b0, {2'b01, lng ? 6'h1a : 6'h1b, idx ? 4'h2 : 4'h0, 4'h4},
            {sl, 15'h0300}, seg};
      issue(c, dd, ds, 16'h0000);
      wait_done(n);
      `CHK("cycles", exp_n, n)
      `CHK("busy at done", 1'b0, busy)
      // an overflowed quotient is still written, only a zero divisor holds it back
      `CHK("dst_we", kind != 1, res.dst_we)
      `CHK("ovf", kind != 0, res.ovf)
      if (kind == 0) `CHK("dst", lng ? exp_d : {32'h0000_0000, exp_d[31:0]}, lng ? res.dst : {32'h0000_0000, res.dst[31:0]})
   endtask : div_case

   task automatic loop_case(input logic byt, input logic [15:0] ct, input logic [6:0] disp,
                            input logic [15:0] exp_c);
      dlb_pkg::dlb_cmd_t c;
      int                n;
      logic              taken;
      c = '{1'b1, byt, {4'hf, 4'h3, ~byt, disp}, 16'h0000, 1'b1};
      taken = byt ? (exp_c[7:0] != 8'h00) : (exp_c != 16'h0000);
      issue(c, 64'h0000_0000_0000_0000, 32'h0000_0000, ct);
      wait_done(n);
      `CHK("loop cycles", 11, n)
      `CHK("cnt_we", 1'b1, cnt_we)
      `CHK("cnt", byt ? {8'h00, exp_c[7:0]} : exp_c, byt ? {8'h00, cnt_out[7:0]} : cnt_out)
      if (taken) `CHK("pc_we", 1'b1, pc_we)
      if (taken) `CHK("pc", 16'h1000 - {8'h00, disp, 1'b0}, pc_out)
      if (!taken && pc_we === 1'b1) `CHK("pc", 16'h1000, pc_out)
      `CHK("segment", 7'h2a, pc_seg_out)
      `CHK("flag_we", 1'b0, res.flag_we)
      @(posedge ref_clk);
      #1;
      `CHK("busy after loop", 1'b0, busy)
   endtask : loop_case

   // a start while busy must not disturb the divide; a register-mode divide is refused
   task automatic refuse_case;
      dlb_pkg::dlb_cmd_t c;
      int                n;
      c = '{1'b0, 1'b0, {2'b01, 6'h1b, 4'h0, 4'h4}, 16'h0000, 1'b0};
      issue(c, 64'h0000_0000_0000_0022, 32'h0000_0006, 16'h0000);
      repeat (3) @(posedge ref_clk);
      cmd <= '{1'b1, 1'b0, 16'hf385, 16'h0000, 1'b1};
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      wait_done(n);
      `CHK("busy cycles", 104, n)
      `CHK("cnt_we busy", 1'b0, cnt_we)
      `CHK("dst busy", 32'h0004_0005, res.dst[31:0])
      c.op_word = {2'b10, 6'h1b, 4'h3, 4'h4};
      issue(c, 64'h0000_0000_0000_0022, 32'h0000_0006, 16'h0000);
      wait_done(n);
      `CHK("no done", 1, n >= 1200)
      `CHK("illegal", 1'b1, illegal)
   endtask : refuse_case

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK("busy reset", 1'b0, busy)
      div_case(0, 0, 0, 0, 64'h0000_0000_0000_0022, 32'h0000_0006, 108, 0, 64'h0000_0000_0004_0005);
      div_case(0, 1, 0, 0, 64'h0000_0000_ffff_ffde, 32'h0000_0006, 109, 0, 64'h0000_0000_fffc_fffb);
      div_case(0, 1, 1, 0, 64'h0000_0000_ffff_ffde, 32'h0000_0006, 111, 0, 64'h0000_0000_fffc_fffb);
      div_case(1, 0, 0, 0, 64'hffff_ffff_ffff_fff9, 32'h0000_0002, 445, 0, 64'hffff_ffff_ffff_fffd);
      div_case(1, 1, 0, 0, 64'hffff_ffff_ffff_fff9, 32'h0000_0002, 746, 0, 64'hffff_ffff_ffff_fffd);
      div_case(1, 1, 1, 0, 64'h0000_0000_0000_0022, 32'h0000_0006, 748, 0, 64'h0000_0004_0000_0005);
      div_case(0, 1, 1, 1, 64'h0000_0000_0000_0022, 32'h0000_0006, 112, 0, 64'h0000_0000_0004_0005);
      div_case(1, 1, 1, 1, 64'h0000_0000_0000_0022, 32'h0000_0006, 749, 0, 64'h0000_0004_0000_0005);
      div_case(0, 0, 0, 0, 64'h0000_0000_0000_0022, 32'h0000_0000, 14, 1, 64'h0);
      div_case(1, 1, 1, 0, 64'hffff_ffff_ffff_fff9, 32'h0000_0000, 34, 1, 64'h0);
      div_case(0, 0, 0, 0, 64'h0000_0000_0001_0000, 32'h0000_0001, 26, 2, 64'h0);
      div_case(1, 1, 0, 0, 64'h0000_0001_0000_0000, 32'h0000_0001, 53, 2, 64'h0);
      loop_case(0, 16'h0005, 7'h7f, 16'h0004);
      loop_case(0, 16'h0001, 7'h05, 16'h0000);
      loop_case(1, 16'hab00, 7'h00, 16'h00ff);
      loop_case(0, 16'h0000, 7'h01, 16'hffff);
      refuse_case();
      test_done();
   end

   // all scenarios together need well under 6000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      test_done();
   end
endmodule : divide_and_loop_branch_exec_tb
